// ===== hw/tcsp_params.svh
// timing and encoding constants for the type-c source protection controller
`ifndef TCSP_PARAMS_SVH
`define TCSP_PARAMS_SVH

`define TCSP_CLK_MHZ          125
// overcurrent report deglitch, in microseconds
`define TCSP_OC_DEGLITCH_US   8000
`define TCSP_OC_DEGLITCH_CYC  (`TCSP_OC_DEGLITCH_US * `TCSP_CLK_MHZ)
// soft-start ramp into short, in microseconds
`define TCSP_RAMP_US          100
`define TCSP_RAMP_CYC         (`TCSP_RAMP_US * `TCSP_CLK_MHZ)
// overload response window, in nanoseconds
`define TCSP_OL_RESP_NS       80
`define TCSP_OL_RESP_CYC      (`TCSP_OL_RESP_NS / 8)
// limit codes in tenths of an ampere
`define TCSP_LIM_1A7          8'h11
`define TCSP_LIM_3A4          8'h22
`define TCSP_LD_THR_1A95      8'h14

`endif

// ===== hw/tcsp_pkg.sv
// types for the type-c source protection controller
package tcsp_pkg;
  typedef enum logic [1:0] {
    TCSP_ADV_DEFAULT,
    TCSP_ADV_1A5,
    TCSP_ADV_3A0
  } tcsp_adv_e;

  typedef enum logic [2:0] {
    TCSP_ST_OFF,
    TCSP_ST_RAMP,
    TCSP_ST_NORMAL,
    TCSP_ST_LIMIT,
    TCSP_ST_THERM_OFF,
    TCSP_ST_SHUTDOWN
  } tcsp_state_e;
endpackage

// ===== hw/tcsp_sync.sv
// two-flop synchroniser for a bundle of asynchronous inputs
module tcsp_sync #(
  parameter int WIDTH = 1
) (
  // clocking
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else if (clk_en)
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// ===== hw/tcsp_deglitch.sv
// counter filter: output follows input only after it stays stable
module tcsp_deglitch #(
  parameter int CYCLES = 1000000
) (
  // clocking
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  // data
  input  wire logic raw_in,
  output logic      filt_out
);
  logic [$clog2(CYCLES+1)-1:0] cnt_reg;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cnt_reg  <= '0;
      filt_out <= 1'b0;
    end
    else if (clk_en)
    begin
      if (raw_in == filt_out)
        cnt_reg <= '0;
      else if (cnt_reg == ($clog2(CYCLES+1))'(CYCLES - 1))
      begin
        cnt_reg  <= '0;
        filt_out <= raw_in;
      end
      else
        cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule

// ===== hw/tcsp_ctrl.sv
// type-c source advertisement, protection and accessory detection control
// Functional notes
// - level/max selects pick default, 1.5A or 3A advertisement and 1.7A or 3.4A limit
// - load detect runs only at 3A advertisement, 1.95A threshold
// - overload holds constant-current regulation instead of switching off
// - enabling into a short ramps to short-circuit current and holds it
// - overload after full turn-on handled within the response window
// - in current limit, thermal trip turns off until 20C cooler, then retries
// - undervoltage lockout holds switch off; hysteresis comes from the comparator
// - alarm goes low on overcurrent or first thermal threshold
// - alarm stays low until the cause clears and normal operation resumes
// - overcurrent is deglitched before it reaches the alarm
// - first thermal threshold asserts alarm and disables the switch
// - second thermal threshold releases all flags and disables; retry after cooling
// - both CC lines at Ra flag a headset adapter
// - headset adapter detach watches CC2 only
// - both CC lines at Rd flag a test accessory
// - test accessory detach watches CC1 only
// - status flags are open-drain, active low, low or released
// - enable low opens both switches, releases flags, stops CC monitoring
// - load detect flag low while current exceeds 1.95A
`include "tcsp_params.svh"
module tcsp_ctrl
  import tcsp_pkg::*;
#(
  parameter int OC_DEGLITCH_CYC = `TCSP_OC_DEGLITCH_CYC,
  parameter int RAMP_CYC        = `TCSP_RAMP_CYC
) (
  // clocking
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // pins from outside the clock domain
  input  wire logic       dev_enable,
  input  wire logic       adv_level_select,
  input  wire logic       adv_max_select,
  input  wire logic       supply_ok,
  // analog comparator results
  input  wire logic       overcurrent_det,
  input  wire logic       load_over_thr,
  input  wire logic       temp_warn_threshold,
  input  wire logic       temp_kill_threshold,
  input  wire logic       temp_cooled,
  input  wire logic       cc1_is_ra,
  input  wire logic       cc1_is_rd,
  input  wire logic       cc2_is_ra,
  input  wire logic       cc2_is_rd,
  // attach results from the classification logic
  input  wire logic       ufp_attached,
  input  wire logic       ufp_flipped,
  // power path control
  output logic            charge_supply_on,
  output logic            cable_power_supply_on,
  output logic            current_limit_active,
  output logic            short_circuit_current,
  output logic [7:0]      selected_current_limit,
  output logic [7:0]      load_detect_threshold,
  output logic            load_detect_en,
  output logic [1:0]      cc_advertise,
  output logic            cc_monitor_en,
  output logic [2:0]      prot_state,
  // open-drain flags: low drives the pin low
  output logic            protection_alarm_n_o,
  output logic            protection_alarm_n_oe,
  output logic            heavy_draw_flag_n_o,
  output logic            heavy_draw_flag_n_oe,
  output logic            sink_present_n_o,
  output logic            sink_present_n_oe,
  output logic            flip_indicator_n_o,
  output logic            flip_indicator_n_oe,
  output logic            headset_adapter_flag_n_o,
  output logic            headset_adapter_flag_n_oe,
  output logic            test_accessory_flag_n_o,
  output logic            test_accessory_flag_n_oe
);
  localparam int NSYNC = 15;
  localparam int RW    = $clog2(RAMP_CYC + 1);

  typedef struct packed {
    tcsp_state_e      st;
    logic [RW-1:0]    ramp_cnt;
    logic             alarm;
    logic             headset;
    logic             testacc;
    logic             heavy;
    logic             sink;
    logic             flip;
    tcsp_adv_e        adv;
    logic             vbus_on;
    logic             vconn_on;
  } tcsp_ctrl_s;

  tcsp_ctrl_s state_reg;
  tcsp_ctrl_s state_next;

  logic [NSYNC-1:0] raw_vec;
  logic [NSYNC-1:0] sync_vec;
  logic en_s, lvl_s, max_s, uv_ok_s, oc_s, ld_s, warn_s, kill_s, cool_s;
  logic c1ra_s, c1rd_s, c2ra_s, c2rd_s, ufp_s, flip_s;
  logic oc_filt;

  assign raw_vec = {dev_enable, adv_level_select, adv_max_select, supply_ok, overcurrent_det,
                    load_over_thr, temp_warn_threshold, temp_kill_threshold, temp_cooled,
                    cc1_is_ra, cc1_is_rd, cc2_is_ra, cc2_is_rd, ufp_attached, ufp_flipped};

  // every pin and comparator through two flops
  tcsp_sync #(.WIDTH(NSYNC)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .async_in (raw_vec),
    .sync_out (sync_vec)
  );

  assign {en_s, lvl_s, max_s, uv_ok_s, oc_s, ld_s, warn_s, kill_s, cool_s,
          c1ra_s, c1rd_s, c2ra_s, c2rd_s, ufp_s, flip_s} = sync_vec;

  // transient current spikes must not reach the alarm
  tcsp_deglitch #(.CYCLES(OC_DEGLITCH_CYC)) u_oc_dg (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .raw_in   (oc_s),
    .filt_out (oc_filt)
  );

  function automatic tcsp_adv_e adv_decode(input logic lvl, input logic mx);
    if (!lvl)
      return TCSP_ADV_DEFAULT;
    else if (!mx)
      return TCSP_ADV_1A5;
    else
      return TCSP_ADV_3A0;
  endfunction

  function automatic logic [7:0] limit_of(input tcsp_adv_e a);
    return (a == TCSP_ADV_3A0) ? `TCSP_LIM_3A4 : `TCSP_LIM_1A7;
  endfunction

  logic powered;
  assign powered = en_s && uv_ok_s;

  always_comb
  begin
    state_next = state_reg;
    state_next.adv = adv_decode(lvl_s, max_s);
    unique case (state_reg.st)
      TCSP_ST_OFF:
      begin
        state_next.ramp_cnt = '0;
        if (powered)
          state_next.st = TCSP_ST_RAMP;
      end
      TCSP_ST_RAMP:
      begin
        // enabled into a short: climb to the fold-back level, then regulate
        if (state_reg.ramp_cnt == RW'(RAMP_CYC - 1))
          state_next.st = oc_s ? TCSP_ST_LIMIT : TCSP_ST_NORMAL;
        else
          state_next.ramp_cnt = state_reg.ramp_cnt + 1'b1;
      end
      TCSP_ST_NORMAL:
        if (oc_s)
          state_next.st = TCSP_ST_LIMIT;
      TCSP_ST_LIMIT:
        if (warn_s)
          state_next.st = TCSP_ST_THERM_OFF;
        else if (!oc_s)
          state_next.st = TCSP_ST_NORMAL;
      TCSP_ST_THERM_OFF:
        if (cool_s && !warn_s)
          state_next.st = TCSP_ST_RAMP;
      TCSP_ST_SHUTDOWN:
        if (cool_s && !kill_s)
          state_next.st = TCSP_ST_OFF;
    endcase
    // warn outside current limit still disables the switch
    // judged on the next state so a start-up or new overload under warn cannot close the switch
    if (warn_s && (state_next.st == TCSP_ST_NORMAL || state_next.st == TCSP_ST_RAMP
                   || state_next.st == TCSP_ST_LIMIT))
      state_next.st = TCSP_ST_THERM_OFF;
    if (kill_s)
      state_next.st = TCSP_ST_SHUTDOWN;
    else if (!powered)
      state_next.st = TCSP_ST_OFF;
    if (state_next.st == TCSP_ST_RAMP && state_reg.st != TCSP_ST_RAMP)
      state_next.ramp_cnt = '0;

    state_next.vbus_on  = ufp_s && (state_next.st == TCSP_ST_RAMP || state_next.st == TCSP_ST_NORMAL
                                    || state_next.st == TCSP_ST_LIMIT);
    state_next.vconn_on = state_next.vbus_on && ((c1rd_s && c2ra_s) || (c1ra_s && c2rd_s));

    // alarm stays until cause gone and back in normal
    if (oc_filt || warn_s)
      state_next.alarm = 1'b1;
    else if (state_next.st == TCSP_ST_NORMAL)
      state_next.alarm = 1'b0;

    state_next.heavy = (state_next.adv == TCSP_ADV_3A0) && ld_s && state_next.vbus_on;

    // attach on both lines, detach on one line only
    if (c1ra_s && c2ra_s)
      state_next.headset = 1'b1;
    else if (!c2ra_s)
      state_next.headset = 1'b0;
    if (c1rd_s && c2rd_s)
      state_next.testacc = 1'b1;
    else if (!c1rd_s)
      state_next.testacc = 1'b0;
    state_next.sink = ufp_s && !(c1rd_s && c2rd_s);
    state_next.flip = state_next.sink && flip_s;

    // monitoring is off while disabled or shut down
    if (state_next.st == TCSP_ST_OFF || state_next.st == TCSP_ST_SHUTDOWN)
    begin
      state_next.headset = 1'b0;
      state_next.testacc = 1'b0;
      state_next.sink    = 1'b0;
      state_next.flip    = 1'b0;
      state_next.heavy   = 1'b0;
      state_next.alarm   = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_reg     <= '0;
      state_reg.st  <= TCSP_ST_OFF;
      state_reg.adv <= TCSP_ADV_DEFAULT;
    end
    else if (clk_en)
      state_reg <= state_next;
  end

  assign charge_supply_on       = state_reg.vbus_on;
  assign cable_power_supply_on  = state_reg.vconn_on;
  assign current_limit_active   = state_reg.st == TCSP_ST_LIMIT;
  assign short_circuit_current  = state_reg.st == TCSP_ST_LIMIT || state_reg.st == TCSP_ST_RAMP;
  assign selected_current_limit = limit_of(state_reg.adv);
  assign load_detect_en         = state_reg.adv == TCSP_ADV_3A0;
  assign load_detect_threshold  = load_detect_en ? `TCSP_LD_THR_1A95 : 8'h00;
  assign cc_advertise           = state_reg.adv;
  assign cc_monitor_en          = state_reg.st != TCSP_ST_OFF && state_reg.st != TCSP_ST_SHUTDOWN;
  assign prot_state             = state_reg.st;

  // open drain: data always low, enable carries the flag
  assign protection_alarm_n_o      = 1'b0;
  assign protection_alarm_n_oe     = state_reg.alarm;
  assign heavy_draw_flag_n_o       = 1'b0;
  assign heavy_draw_flag_n_oe      = state_reg.heavy;
  assign sink_present_n_o          = 1'b0;
  assign sink_present_n_oe         = state_reg.sink;
  assign flip_indicator_n_o        = 1'b0;
  assign flip_indicator_n_oe       = state_reg.flip;
  assign headset_adapter_flag_n_o  = 1'b0;
  assign headset_adapter_flag_n_oe = state_reg.headset;
  assign test_accessory_flag_n_o   = 1'b0;
  assign test_accessory_flag_n_oe  = state_reg.testacc;

  a_kill_releases: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && kill_s |=> state_reg.st == TCSP_ST_SHUTDOWN && !protection_alarm_n_oe && !sink_present_n_oe)
    else $error("shutdown did not release flags");
  a_disable_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && !en_s |=> !charge_supply_on && !cable_power_supply_on && !headset_adapter_flag_n_oe)
    else $error("disable did not open switches");
  a_warn_alarm: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && warn_s && !kill_s && powered && state_reg.st != TCSP_ST_SHUTDOWN
    |=> protection_alarm_n_oe && !charge_supply_on)
    else $error("warn threshold did not alarm");
  a_limit_map: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && lvl_s && max_s |=> selected_current_limit == `TCSP_LIM_3A4)
    else $error("3A limit not selected");
  a_heavy_only3a: assert property (@(posedge core_clk) disable iff (!rst_n)
    heavy_draw_flag_n_oe |-> load_detect_en)
    else $error("load detect outside 3A");
  a_headset_det: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && c1ra_s && c2ra_s && cc_monitor_en && powered && !kill_s |=> headset_adapter_flag_n_oe)
    else $error("headset adapter missed");
  a_headset_cc2: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && headset_adapter_flag_n_oe && c2ra_s && powered && !kill_s |=> headset_adapter_flag_n_oe)
    else $error("headset dropped while CC2 Ra");
  a_testacc_cc1: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && test_accessory_flag_n_oe && !c1rd_s |=> !test_accessory_flag_n_oe)
    else $error("test accessory held after CC1 detach");
  a_limit_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && state_reg.st == TCSP_ST_LIMIT && oc_s && !warn_s && !kill_s && powered
    |=> state_reg.st == TCSP_ST_LIMIT)
    else $error("limit left during overload");
  a_overload_resp: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && state_reg.st == TCSP_ST_NORMAL && oc_s && !warn_s && !kill_s && powered
    |=> state_reg.st == TCSP_ST_LIMIT)
    else $error("overload not limited on next cycle");
endmodule

// ===== tb/tcsp_far_end.sv
// behavioural far side: sink, cable or accessory terminations and vbus load
module tcsp_far_end (
  // requested terminations (0 open, 1 ra, 2 rd) and load (3 overload)
  input  wire logic [1:0] cc1_term,
  input  wire logic [1:0] cc2_term,
  input  wire logic [1:0] draw_level,
  input  wire logic       vbus_on,
  // classified levels toward the controller
  output logic            cc1_is_ra,
  output logic            cc1_is_rd,
  output logic            cc2_is_ra,
  output logic            cc2_is_rd,
  output logic            ufp_attached,
  output logic            ufp_flipped,
  output logic            overcurrent_det,
  output logic            load_over_thr
);
  timeunit 1ns;
  timeprecision 1ps;
  assign cc1_is_ra = (cc1_term == 2'h1);
  assign cc1_is_rd = (cc1_term == 2'h2);
  assign cc2_is_ra = (cc2_term == 2'h1);
  assign cc2_is_rd = (cc2_term == 2'h2);
  assign ufp_attached = cc1_is_rd | cc2_is_rd;
  assign ufp_flipped = cc2_is_rd & ~cc1_is_rd;
  // no current flows while the switch is open
  assign load_over_thr = vbus_on & (draw_level >= 2'h2);
  assign overcurrent_det = vbus_on & (draw_level == 2'h3);
endmodule

// ===== tb/tb.sv
// self-checking bench for the type-c source protection controller
`include "tcsp_params.svh"
module tb
  import tcsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk, rst_n, dev_enable, adv_level_select, adv_max_select, supply_ok;
  logic       temp_warn_threshold, temp_kill_threshold, temp_cooled, acc, clk_en;
  wire [5:0]  pins_o;
  logic [1:0] cc1_term, cc2_term, draw_level;
  wire        cc1_is_ra, cc1_is_rd, cc2_is_ra, cc2_is_rd, ufp_attached, ufp_flipped;
  wire        overcurrent_det, load_over_thr, charge_supply_on, cable_power_supply_on;
  wire        current_limit_active, short_circuit_current, load_detect_en, cc_monitor_en;
  wire [7:0]  selected_current_limit, load_detect_threshold;
  wire [1:0]  cc_advertise;
  wire [2:0]  prot_state;
  wire        alarm_oe, heavy_oe, sink_oe, flip_oe, headset_oe, test_oe;
  int         miscompares, samples_checked, cyc;

  tcsp_far_end far (.cc1_term(cc1_term), .cc2_term(cc2_term), .draw_level(draw_level),
    .vbus_on(charge_supply_on), .cc1_is_ra(cc1_is_ra), .cc1_is_rd(cc1_is_rd), .cc2_is_ra(cc2_is_ra),
    .cc2_is_rd(cc2_is_rd), .ufp_attached(ufp_attached), .ufp_flipped(ufp_flipped),
    .overcurrent_det(overcurrent_det), .load_over_thr(load_over_thr));

  tcsp_ctrl #(.OC_DEGLITCH_CYC(4), .RAMP_CYC(3)) dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .dev_enable(dev_enable), .adv_level_select(adv_level_select), .adv_max_select(adv_max_select),
    .supply_ok(supply_ok), .overcurrent_det(overcurrent_det), .load_over_thr(load_over_thr),
    .temp_warn_threshold(temp_warn_threshold), .temp_kill_threshold(temp_kill_threshold),
    .temp_cooled(temp_cooled), .cc1_is_ra(cc1_is_ra), .cc1_is_rd(cc1_is_rd), .cc2_is_ra(cc2_is_ra),
    .cc2_is_rd(cc2_is_rd), .ufp_attached(ufp_attached), .ufp_flipped(ufp_flipped),
    .charge_supply_on(charge_supply_on), .cable_power_supply_on(cable_power_supply_on),
    .current_limit_active(current_limit_active), .short_circuit_current(short_circuit_current),
    .selected_current_limit(selected_current_limit), .load_detect_threshold(load_detect_threshold),
    .load_detect_en(load_detect_en), .cc_advertise(cc_advertise), .cc_monitor_en(cc_monitor_en),
    .prot_state(prot_state), .protection_alarm_n_o(pins_o[0]), .protection_alarm_n_oe(alarm_oe),
    .heavy_draw_flag_n_o(pins_o[1]), .heavy_draw_flag_n_oe(heavy_oe), .sink_present_n_o(pins_o[2]),
    .sink_present_n_oe(sink_oe), .flip_indicator_n_o(pins_o[3]), .flip_indicator_n_oe(flip_oe),
    .headset_adapter_flag_n_o(pins_o[4]), .headset_adapter_flag_n_oe(headset_oe),
    .test_accessory_flag_n_o(pins_o[5]), .test_accessory_flag_n_oe(test_oe));

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // a hang is cut short well after the sequence should have ended
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  initial
  begin
    {dev_enable, adv_level_select, adv_max_select, supply_ok} = 4'h0;
    {temp_warn_threshold, temp_kill_threshold, temp_cooled} = 3'h0;
    cc1_term = 2'h0;
    cc2_term = 2'h0;
    draw_level = 2'h0;
    clk_en = 1'b1;
    rst_n = 1'b0;
    wt(8);
    chk(8'(prot_state), 8'(TCSP_ST_OFF));
    chk(8'({charge_supply_on, sink_oe, alarm_oe}), 8'h00);
    rst_n = 1'b1;
    done("reset");
    // enabled straight into a short
    draw_level = 2'h3;
    cc1_term = 2'h2;
    {dev_enable, supply_ok, adv_level_select, adv_max_select} = 4'hF;
    wt(14);
    chk(8'(prot_state), 8'(TCSP_ST_LIMIT));
    chk(8'({current_limit_active, short_circuit_current, charge_supply_on}), 8'h07);
    chk(8'(alarm_oe), 8'h01);
    draw_level = 2'h0;
    wt(12);
    chk(8'(prot_state), 8'(TCSP_ST_NORMAL));
    chk(8'({alarm_oe, short_circuit_current, sink_oe}), 8'h01);
    done("short");
    for (int i = 0; i < 4; i++)
    begin
      adv_level_select = i[1];
      adv_max_select = i[0];
      wt(5);
      chk(8'(cc_advertise), 8'(i[1] ? (i[0] ? TCSP_ADV_3A0 : TCSP_ADV_1A5) : TCSP_ADV_DEFAULT));
      chk(selected_current_limit, (i == 3) ? `TCSP_LIM_3A4 : `TCSP_LIM_1A7);
      chk(load_detect_threshold, (i == 3) ? `TCSP_LD_THR_1A95 : 8'h00);
      chk(8'(load_detect_en), 8'(i == 3));
    end
    done("advertise");
    draw_level = 2'h2;
    wt(5);
    chk(8'(heavy_oe), 8'h01);
    adv_max_select = 1'b0;
    wt(5);
    chk(8'(heavy_oe), 8'h00);
    adv_max_select = 1'b1;
    draw_level = 2'h0;
    wt(5);
    chk(8'(heavy_oe), 8'h00);
    done("load detect");
    // a two-cycle spike is shorter than the filter
    draw_level = 2'h3;
    wt(2);
    draw_level = 2'h0;
    acc = 1'b0;
    repeat (12)
    begin
      wt(1);
      acc = acc | alarm_oe;
    end
    chk(8'(acc), 8'h00);
    draw_level = 2'h3;
    wt(4);
    chk(8'(prot_state), 8'(TCSP_ST_LIMIT));
    chk(8'(charge_supply_on), 8'h01);
    wt(8);
    chk(8'(alarm_oe), 8'h01);
    done("overload");
    temp_warn_threshold = 1'b1;
    wt(5);
    chk(8'(prot_state), 8'(TCSP_ST_THERM_OFF));
    chk(8'({charge_supply_on, alarm_oe}), 8'h01);
    temp_warn_threshold = 1'b0;
    draw_level = 2'h0;
    wt(5);
    chk(8'(alarm_oe), 8'h01);
    temp_cooled = 1'b1;
    wt(12);
    chk(8'(prot_state), 8'(TCSP_ST_NORMAL));
    chk(8'(alarm_oe), 8'h00);
    temp_cooled = 1'b0;
    temp_kill_threshold = 1'b1;
    wt(5);
    chk(8'(prot_state), 8'(TCSP_ST_SHUTDOWN));
    chk(8'({charge_supply_on, sink_oe, alarm_oe}), 8'h00);
    temp_kill_threshold = 1'b0;
    temp_cooled = 1'b1;
    wt(12);
    chk(8'({charge_supply_on, sink_oe}), 8'h03);
    temp_cooled = 1'b0;
    done("thermal");
    cc1_term = 2'h1;
    cc2_term = 2'h2;
    wt(8);
    chk(8'({flip_oe, sink_oe, cable_power_supply_on}), 8'h07);
    chk(8'(pins_o), 8'h00);
    done("cable");
    cc1_term = 2'h1;
    cc2_term = 2'h1;
    wt(6);
    chk(8'({headset_oe, sink_oe}), 8'h02);
    cc1_term = 2'h0;
    wt(6);
    chk(8'(headset_oe), 8'h01);
    cc2_term = 2'h0;
    wt(6);
    chk(8'(headset_oe), 8'h00);
    cc1_term = 2'h2;
    cc2_term = 2'h2;
    wt(6);
    chk(8'({test_oe, sink_oe}), 8'h02);
    cc2_term = 2'h0;
    wt(6);
    chk(8'(test_oe), 8'h01);
    cc1_term = 2'h0;
    wt(6);
    chk(8'(test_oe), 8'h00);
    done("accessory");
    cc1_term = 2'h2;
    wt(12);
    chk(8'(cc_monitor_en), 8'h01);
    dev_enable = 1'b0;
    wt(6);
    chk(8'({charge_supply_on, cable_power_supply_on, sink_oe, cc_monitor_en}), 8'h00);
    chk(8'(prot_state), 8'(TCSP_ST_OFF));
    dev_enable = 1'b1;
    supply_ok = 1'b0;
    wt(8);
    chk(8'({charge_supply_on, prot_state}), 8'(TCSP_ST_OFF));
    supply_ok = 1'b1;
    wt(12);
    chk(8'(charge_supply_on), 8'h01);
    done("enable");
    // enable low must not act while the clock enable freezes the block
    clk_en = 1'b0;
    dev_enable = 1'b0;
    wt(8);
    chk(8'({charge_supply_on, cc_monitor_en}), 8'h03);
    clk_en = 1'b1;
    wt(6);
    chk(8'({charge_supply_on, cc_monitor_en}), 8'h00);
    done("freeze");
    end_of_test();
  end
endmodule
